// ---- pkg/mbsc_pkg.sv ----
// Constants, opcodes and states shared by the six-instruction execution block.
package mbsc_pkg;
    localparam int unsigned MBSC_DATA_W = 8;
    localparam int unsigned MBSC_ADDR_W = 7;
    localparam int unsigned MBSC_PC_W = 11;
    localparam int unsigned MBSC_PAGE_W = 3;
    localparam int unsigned MBSC_BIT_W = 3;
    localparam int unsigned MBSC_SP_W = 3;
    localparam int unsigned MBSC_STACK_DEPTH = 8;
    localparam logic [MBSC_DATA_W-1:0] MBSC_ZERO_BYTE = 8'h00;
    localparam logic [MBSC_DATA_W-1:0] MBSC_RESET_WORK = 8'h00;
    localparam logic [MBSC_PC_W-1:0] MBSC_RESET_PC = 11'h000;
    localparam logic [MBSC_PC_W-1:0] MBSC_PC_ONE = 11'h001;
    localparam logic [MBSC_SP_W-1:0] MBSC_RESET_SP = 3'h0;
    localparam logic [MBSC_SP_W-1:0] MBSC_SP_ONE = 3'h1;
    localparam logic MBSC_RESET_ZERO = 1'b0;
    localparam logic MBSC_RESET_TIMEOUT = 1'b1;
    localparam logic MBSC_RESET_POWERDOWN = 1'b1;

    typedef enum logic [2:0] {
        MBSC_OP_NONE,
        MBSC_OP_BIT_TEST_SKIP_IF_SET,
        MBSC_OP_INDIRECT_SUBROUTINE_CALL,
        MBSC_OP_CLEAR_WORKING_REGISTER,
        MBSC_OP_WATCHDOG_CLEAR_OP,
        MBSC_OP_CLEAR_DATA_REGISTER,
        MBSC_OP_COMPLEMENT_REGISTER
    } mbsc_op_t;

    typedef enum logic [1:0] {
        MBSC_ST_EXEC,
        MBSC_ST_SKIP,
        MBSC_ST_CALL
    } mbsc_state_t;
endpackage

// ---- rtl/mbsc_exec.sv ----
// Execution unit for bit-skip, indirect call, clears, watchdog clear and complement.
`timescale 1ns/10ps
module mbsc_exec (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire mbsc_pkg::mbsc_op_t op_code,
    input wire logic [mbsc_pkg::MBSC_ADDR_W-1:0] op_addr,
    input wire logic [mbsc_pkg::MBSC_BIT_W-1:0] op_bit,
    input wire logic op_dest,
    input wire logic [mbsc_pkg::MBSC_DATA_W-1:0] reg_rdata,
    input wire logic [mbsc_pkg::MBSC_PAGE_W-1:0] table_high_page,
    input wire logic prescaler_to_watchdog,
    input wire logic timeout_event,
    input wire logic powerdown_entry,
    output logic [mbsc_pkg::MBSC_ADDR_W-1:0] reg_addr,
    output logic reg_we,
    output logic [mbsc_pkg::MBSC_DATA_W-1:0] reg_wdata,
    output logic [mbsc_pkg::MBSC_DATA_W-1:0] working_register,
    output logic zero_flag,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic watchdog_counter_clear,
    output logic shared_prescaler_clear,
    output logic [mbsc_pkg::MBSC_PC_W-1:0] pc,
    output logic [mbsc_pkg::MBSC_SP_W-1:0] stack_pointer,
    output logic [mbsc_pkg::MBSC_PC_W-1:0] stack_top,
    output logic op_ready,
    output logic fetched_discarded
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mbsc_pkg::mbsc_state_t state;
    mbsc_pkg::mbsc_state_t next_state;
    logic [mbsc_pkg::MBSC_DATA_W-1:0] next_working_register;
    logic next_zero_flag;
    logic next_timeout_flag;
    logic next_powerdown_flag;
    logic next_watchdog_counter_clear;
    logic next_shared_prescaler_clear;
    logic [mbsc_pkg::MBSC_PC_W-1:0] pc_next_seq;
    logic [mbsc_pkg::MBSC_PC_W-1:0] next_pc;
    logic [mbsc_pkg::MBSC_SP_W-1:0] next_stack_pointer;
    logic [mbsc_pkg::MBSC_PC_W-1:0] stack_mem [mbsc_pkg::MBSC_STACK_DEPTH];
    logic [mbsc_pkg::MBSC_PC_W-1:0] next_push_value;
    logic next_push;
    logic [mbsc_pkg::MBSC_PC_W-1:0] call_target;
    logic next_fetched_discarded;
    logic [mbsc_pkg::MBSC_DATA_W-1:0] inverted;
    logic take;
    logic watchdog_clear_taken;
    logic [mbsc_pkg::MBSC_PC_W-1:0] next_stack_mem [mbsc_pkg::MBSC_STACK_DEPTH];

    // ------------------------------------------------------------
    // Combinational paths
    // ------------------------------------------------------------
    // Reads and writes go straight to the register file in the same cycle.
    assign reg_addr = op_addr;
    assign inverted = ~reg_rdata;
    assign take = op_valid && op_ready;
    assign watchdog_clear_taken = take && (op_code == mbsc_pkg::MBSC_OP_WATCHDOG_CLEAR_OP);
    assign pc_next_seq = pc + mbsc_pkg::MBSC_PC_ONE;
    assign call_target = {table_high_page, working_register};
    assign stack_top = stack_mem[stack_pointer - mbsc_pkg::MBSC_SP_ONE];

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_working_register = working_register;
        next_zero_flag = zero_flag;
        next_pc = pc;
        next_stack_pointer = stack_pointer;
        next_push = 1'b0;
        next_push_value = pc_next_seq;
        next_fetched_discarded = 1'b0;
        reg_we = 1'b0;
        reg_wdata = mbsc_pkg::MBSC_ZERO_BYTE;
        op_ready = (state == mbsc_pkg::MBSC_ST_EXEC);
        unique case (state)
            mbsc_pkg::MBSC_ST_EXEC: begin
                if (take) begin
                    next_pc = pc_next_seq;
                    unique case (op_code)
                        mbsc_pkg::MBSC_OP_BIT_TEST_SKIP_IF_SET: begin
                            // Flags are left alone by the test.
                            // A skip holds op_ready low one cycle, so a request then is ignored.
                            if (reg_rdata[op_bit]) begin
                                next_state = mbsc_pkg::MBSC_ST_SKIP;
                            end
                        end
                        mbsc_pkg::MBSC_OP_INDIRECT_SUBROUTINE_CALL: begin
                            next_push = 1'b1;
                            next_stack_pointer = stack_pointer + mbsc_pkg::MBSC_SP_ONE;
                            next_pc = call_target;
                            next_state = mbsc_pkg::MBSC_ST_CALL;
                        end
                        mbsc_pkg::MBSC_OP_CLEAR_WORKING_REGISTER: begin
                            next_working_register = mbsc_pkg::MBSC_ZERO_BYTE;
                            next_zero_flag = 1'b1;
                        end
                        mbsc_pkg::MBSC_OP_WATCHDOG_CLEAR_OP: begin
                            // Status flags and watchdog pulses live in their own group.
                        end
                        mbsc_pkg::MBSC_OP_CLEAR_DATA_REGISTER: begin
                            reg_we = 1'b1;
                            // The register file takes the zero at this same edge.
                            reg_wdata = mbsc_pkg::MBSC_ZERO_BYTE;
                            next_zero_flag = 1'b1;
                        end
                        mbsc_pkg::MBSC_OP_COMPLEMENT_REGISTER: begin
                            if (op_dest) begin
                                reg_we = 1'b1;
                                reg_wdata = inverted;
                            end else begin
                                next_working_register = inverted;
                            end
                            // The zero flag follows the result whichever destination takes it.
                            next_zero_flag = (inverted == mbsc_pkg::MBSC_ZERO_BYTE);
                        end
                        default: begin
                            // Other instructions only advance the program counter.
                        end
                    endcase
                end
            end
            mbsc_pkg::MBSC_ST_SKIP: begin
                // The fetched word is dropped and a no-op fills the slot.
                next_pc = pc_next_seq;
                next_fetched_discarded = 1'b1;
                next_state = mbsc_pkg::MBSC_ST_EXEC;
            end
            mbsc_pkg::MBSC_ST_CALL: begin
                // Second call cycle refills the fetch from the new address.
                next_state = mbsc_pkg::MBSC_ST_EXEC;
            end
            default: begin
                // The unused state code falls back to execute.
                next_state = mbsc_pkg::MBSC_ST_EXEC;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= mbsc_pkg::MBSC_ST_EXEC;
            working_register <= mbsc_pkg::MBSC_RESET_WORK;
            zero_flag <= mbsc_pkg::MBSC_RESET_ZERO;
            pc <= mbsc_pkg::MBSC_RESET_PC;
            stack_pointer <= mbsc_pkg::MBSC_RESET_SP;
            fetched_discarded <= 1'b0;
        end else begin
            state <= next_state;
            working_register <= next_working_register;
            zero_flag <= next_zero_flag;
            pc <= next_pc;
            stack_pointer <= next_stack_pointer;
            fetched_discarded <= next_fetched_discarded;
        end
    end

    // ------------------------------------------------------------
    // Status flags and watchdog pulses
    // ------------------------------------------------------------
    always_comb begin
        // Both flags read one after reset; only the core's events below clear them.
        next_timeout_flag = timeout_flag;
        next_powerdown_flag = powerdown_flag;
        next_watchdog_counter_clear = 1'b0;
        next_shared_prescaler_clear = 1'b0;
        if (watchdog_clear_taken) begin
            next_watchdog_counter_clear = 1'b1;
            next_shared_prescaler_clear = prescaler_to_watchdog;
            next_timeout_flag = 1'b1;
            next_powerdown_flag = 1'b1;
        end
        // A timeout or sleep entry in the same cycle wins, so that event is never lost.
        if (timeout_event) begin
            next_timeout_flag = 1'b0;
        end
        if (powerdown_entry) begin
            next_powerdown_flag = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            timeout_flag <= mbsc_pkg::MBSC_RESET_TIMEOUT;
            powerdown_flag <= mbsc_pkg::MBSC_RESET_POWERDOWN;
            watchdog_counter_clear <= 1'b0;
            shared_prescaler_clear <= 1'b0;
        end else begin
            timeout_flag <= next_timeout_flag;
            powerdown_flag <= next_powerdown_flag;
            watchdog_counter_clear <= next_watchdog_counter_clear;
            shared_prescaler_clear <= next_shared_prescaler_clear;
        end
    end

    // ------------------------------------------------------------
    // Return stack
    // ------------------------------------------------------------
    // Stack entries have no reset; until the first push, stack_top shows entry 7, which was never written.
    // The pointer wraps silently, so a ninth nested call overwrites the oldest return.
    always_comb begin
        for (int i = 0; i < mbsc_pkg::MBSC_STACK_DEPTH; i++) begin
            next_stack_mem[i] = stack_mem[i];
        end
        if (next_push) begin
            next_stack_mem[stack_pointer] = next_push_value;
        end
    end

    // Whole-array update keeps this process a plain register stage.
    always_ff @(posedge core_clk) begin
        stack_mem <= next_stack_mem;
    end
endmodule

// ---- dv/mbsc_exec_asserts.sv ----
// Concurrent checks on the ports of the execution block.
`timescale 1ns/10ps
module mbsc_exec_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire mbsc_pkg::mbsc_op_t op_code,
    input wire logic [2:0] op_bit,
    input wire logic op_dest,
    input wire logic [7:0] reg_rdata,
    input wire logic [2:0] table_high_page,
    input wire logic prescaler_to_watchdog,
    input wire logic timeout_event,
    input wire logic powerdown_entry,
    input wire logic reg_we,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] working_register,
    input wire logic zero_flag,
    input wire logic timeout_flag,
    input wire logic powerdown_flag,
    input wire logic watchdog_counter_clear,
    input wire logic shared_prescaler_clear,
    input wire logic [10:0] pc,
    input wire logic [2:0] stack_pointer,
    input wire logic [10:0] stack_top,
    input wire logic op_ready,
    input wire logic fetched_discarded
);
    logic tk, t_sk, t_ca, t_cw, t_wd, t_cd, t_cm, wd_only;
    assign wd_only = t_wd && !timeout_event && !powerdown_entry;
    assign tk = op_valid && op_ready;
    assign t_sk = tk && op_code == mbsc_pkg::MBSC_OP_BIT_TEST_SKIP_IF_SET;
    assign t_ca = tk && op_code == mbsc_pkg::MBSC_OP_INDIRECT_SUBROUTINE_CALL;
    assign t_cw = tk && op_code == mbsc_pkg::MBSC_OP_CLEAR_WORKING_REGISTER;
    assign t_wd = tk && op_code == mbsc_pkg::MBSC_OP_WATCHDOG_CLEAR_OP;
    assign t_cd = tk && op_code == mbsc_pkg::MBSC_OP_CLEAR_DATA_REGISTER;
    assign t_cm = tk && op_code == mbsc_pkg::MBSC_OP_COMPLEMENT_REGISTER;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    AST_SKIP_SET: assert property (t_sk && reg_rdata[op_bit] |=> !op_ready ##1 (op_ready && fetched_discarded))
        else $error("set bit did not discard the next slot");
    AST_SKIP_CLR: assert property (t_sk && !reg_rdata[op_bit] |=> op_ready && !fetched_discarded)
        else $error("clear bit test took more than one cycle");
    AST_CALL_PC: assert property (t_ca |=> pc == {$past(table_high_page), $past(working_register)})
        else $error("call target wrong");
    AST_CALL_PUSH: assert property (t_ca |=> (stack_top == $past(pc) + 11'h001 && stack_pointer == $past(stack_pointer) + 3'h1 && !op_ready) ##1 op_ready)
        else $error("call push or length wrong");
    AST_CLR_WORK: assert property (t_cw |=> working_register == 8'h00 && zero_flag)
        else $error("working register not cleared");
    AST_WD_CLR: assert property (t_wd |=> watchdog_counter_clear && op_ready && shared_prescaler_clear == $past(prescaler_to_watchdog))
        else $error("watchdog clear pulses wrong");
    AST_WD_FLAGS: assert property (wd_only |=> timeout_flag && powerdown_flag)
        else $error("status flags not set");
    AST_CLR_DATA: assert property (t_cd |-> reg_we && reg_wdata == 8'h00 ##1 zero_flag)
        else $error("data register not cleared");
    AST_COMP: assert property (t_cm |-> (op_dest ? reg_we && reg_wdata == ~reg_rdata : !reg_we) ##1 zero_flag == ($past(reg_rdata) == 8'hff))
        else $error("complement write or zero flag wrong");
    AST_COMP_ACC: assert property (t_cm && !op_dest |=> working_register == ~$past(reg_rdata))
        else $error("complement result wrong");
    AST_FLAGS_KEPT: assert property (t_sk || t_ca |=> $stable(zero_flag))
        else $error("skip or call changed the zero flag");
    AST_TIMEOUT_WINS: assert property (timeout_event |=> !timeout_flag)
        else $error("timeout event did not clear the timeout flag");
    AST_SLEEP_WINS: assert property (powerdown_entry |=> !powerdown_flag)
        else $error("sleep entry did not clear the powerdown flag");
    cover property (t_sk && reg_rdata[op_bit]);
    cover property (t_ca);
    cover property (t_cm && op_dest);
    cover property (t_wd && prescaler_to_watchdog);
endmodule
bind mbsc_exec mbsc_exec_asserts chk (.*);

// ---- dv/mbsc_regfile.sv ----
// Data register file model that answers the execution block.
`timescale 1ns/10ps
module mbsc_regfile (
    input wire logic core_clk,
    input wire logic [6:0] reg_addr,
    input wire logic reg_we,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata
);
    logic [7:0] mem [0:127];
    // Contents survive reset, so a distinct pattern shows stray writes.
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(2 * i + 1);
        end
    end
    assign reg_rdata = mem[reg_addr];
    always @(posedge core_clk) begin
        if (reg_we) begin
            mem[reg_addr] <= reg_wdata;
        end
    end
endmodule

// ---- dv/mcu_bit_skip_call_clear_ops_bench.sv ----
// Self-checking bench for the six-instruction execution block.
`timescale 1ns/10ps
module mcu_bit_skip_call_clear_ops_bench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic op_valid = 1'b0;
    mbsc_pkg::mbsc_op_t op_code = mbsc_pkg::MBSC_OP_NONE;
    logic [6:0] op_addr = 7'h00;
    logic [2:0] op_bit = 3'h0;
    logic op_dest = 1'b0;
    logic [2:0] table_high_page = 3'h2;
    logic prescaler_to_watchdog = 1'b0;
    logic timeout_event = 1'b0;
    logic powerdown_entry = 1'b0;
    logic [7:0] reg_rdata, reg_wdata, working_register;
    logic [6:0] reg_addr;
    logic reg_we, zero_flag, timeout_flag, powerdown_flag, op_ready, fetched_discarded;
    logic watchdog_counter_clear, shared_prescaler_clear;
    logic [10:0] pc, stack_top, pc0;
    logic [2:0] stack_pointer;
    int n_fail = 0;
    int check_count = 0;
    always #50 core_clk = ~core_clk;
    mbsc_exec dut (.*);
    mbsc_regfile model (.*);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task results;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task run(input mbsc_pkg::mbsc_op_t c, input logic [6:0] a, input logic [2:0] b, input logic d);
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_code <= c;
        op_addr <= a;
        op_bit <= b;
        op_dest <= d;
        #1 pc0 = pc;
        @(posedge core_clk);
        op_valid <= 1'b0;
        #1;
    endtask
    task t_comp;
        run(mbsc_pkg::MBSC_OP_COMPLEMENT_REGISTER, 7'h05, 3'h0, 1'b0);
        chk({zero_flag, working_register, pc[1:0]}, {1'b0, 8'hf4, pc0[1:0] + 2'h1});
        run(mbsc_pkg::MBSC_OP_COMPLEMENT_REGISTER, 7'h7f, 3'h0, 1'b0);
        chk({zero_flag, working_register}, 9'h100);
        run(mbsc_pkg::MBSC_OP_COMPLEMENT_REGISTER, 7'h05, 3'h0, 1'b1);
        chk({zero_flag, model.mem[5], working_register}, 17'h0_f400);
    endtask
    task t_clear;
        run(mbsc_pkg::MBSC_OP_COMPLEMENT_REGISTER, 7'h05, 3'h0, 1'b0);
        run(mbsc_pkg::MBSC_OP_CLEAR_WORKING_REGISTER, 7'h00, 3'h0, 1'b0);
        chk({zero_flag, working_register}, 9'h100);
        run(mbsc_pkg::MBSC_OP_NONE, 7'h05, 3'h0, 1'b1);
        chk({zero_flag, working_register, pc}, {9'h100, pc0 + 11'h001});
        chk(model.mem[5], 8'hf4);
        run(mbsc_pkg::MBSC_OP_COMPLEMENT_REGISTER, 7'h03, 3'h0, 1'b0);
        run(mbsc_pkg::MBSC_OP_CLEAR_DATA_REGISTER, 7'h7f, 3'h0, 1'b0);
        chk({zero_flag, model.mem[127]}, 9'h100);
    endtask
    task t_skip;
        run(mbsc_pkg::MBSC_OP_BIT_TEST_SKIP_IF_SET, 7'h01, 3'h0, 1'b0);
        chk({op_ready, pc}, {1'b0, pc0 + 11'h001});
        @(posedge core_clk);
        #1 chk({fetched_discarded, zero_flag, pc}, {2'b11, pc0 + 11'h002});
        run(mbsc_pkg::MBSC_OP_BIT_TEST_SKIP_IF_SET, 7'h01, 3'h2, 1'b0);
        chk({op_ready, pc}, {1'b1, pc0 + 11'h001});
        run(mbsc_pkg::MBSC_OP_BIT_TEST_SKIP_IF_SET, 7'h64, 3'h7, 1'b0);
        chk(op_ready, 1'b0);
    endtask
    task t_call;
        run(mbsc_pkg::MBSC_OP_COMPLEMENT_REGISTER, 7'h65, 3'h0, 1'b0);
        run(mbsc_pkg::MBSC_OP_INDIRECT_SUBROUTINE_CALL, 7'h00, 3'h0, 1'b0);
        chk({op_ready, pc}, 12'h234);
        chk({stack_pointer, stack_top}, {3'h1, pc0 + 11'h001});
    endtask
    task t_wdt(input logic p);
        @(posedge core_clk);
        prescaler_to_watchdog <= p;
        timeout_event <= 1'b1;
        powerdown_entry <= 1'b1;
        @(posedge core_clk);
        timeout_event <= 1'b0;
        powerdown_entry <= 1'b0;
        #1 chk({timeout_flag, powerdown_flag}, 2'h0);
        run(mbsc_pkg::MBSC_OP_WATCHDOG_CLEAR_OP, 7'h00, 3'h0, 1'b0);
        chk({watchdog_counter_clear, shared_prescaler_clear}, {1'b1, p});
        chk({timeout_flag, powerdown_flag}, 2'h3);
        @(posedge core_clk);
        #1 chk({watchdog_counter_clear, shared_prescaler_clear}, 2'h0);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        #1 chk({timeout_flag, powerdown_flag, zero_flag, op_ready, pc}, {4'hd, 11'h000});
        t_comp;
        t_clear;
        t_skip;
        t_call;
        t_wdt(1'b1);
        t_wdt(1'b0);
        results;
    end
endmodule
